// file: include/ipsl_consts.svh
// Constants for the IP selection and command-session lock block.
// Assumes a 10 MHz core clock and a rotary selector wired as four pins.
`ifndef IPSL_CONSTS_SVH
`define IPSL_CONSTS_SVH

// Transport ports of the command service
`define IPSL_UDP_PORT      16'h1e5f
`define IPSL_TCP_PORT      16'h1e60

// Preset addresses and masks
`define IPSL_RECOV_ADDR    32'h0a0a0a0a
`define IPSL_NET1_BASE     32'hc0a80100
`define IPSL_NET0_BASE     32'hc0a80000
`define IPSL_HOST_STEP     8'h0a
`define IPSL_MASK_B        32'hffff0000
`define IPSL_MASK_A        32'hff000000

// Selector positions
`define IPSL_SEL_RECOV     4'h0
`define IPSL_SEL_NET1_LAST 4'h3
`define IPSL_SEL_DHCP      4'hf

// Final settle count; the selector synchroniser gets four cycles to fill after reset
`define IPSL_SETTLE_CYC    2'h3

`endif

// file: include/ipsl_pkg.sv
// Types for the IP selection and command-session lock block.
// Assumes ipsl_consts.svh carries the numeric constants.
package ipsl_pkg;
    // Configuration sequencer states
    typedef enum {
        IPSL_ST_SETTLE,
        IPSL_ST_FETCH,
        IPSL_ST_LOAD,
        IPSL_ST_DHCP,
        IPSL_ST_READY
    } ipsl_state_t;
endpackage

// file: rtl/ipsl_addr_table.sv
// Preset address table: one entry per selector position, registered read.
// Assumes the caller gates writes; defaults reload on every reset.
`timescale 1ns/1ps
`default_nettype none
`include "ipsl_consts.svh"
module ipsl_addr_table #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 32
) (
    // Clock and reset
    input  wire logic                     i_mclk,
    input  wire logic                     i_rst_n,
    // Write port
    input  wire logic                     i_we,
    input  wire logic [$clog2(DEPTH)-1:0] i_waddr,
    input  wire logic [WIDTH-1:0]         i_wdata,
    // Read port
    input  wire logic [$clog2(DEPTH)-1:0] i_raddr,
    output logic      [WIDTH-1:0]         o_rdata
);
    // Table storage
    logic [WIDTH-1:0] mem_r [DEPTH];
    // Registered read data
    logic [WIDTH-1:0] rdata_r;

    // Index width of the write port
    localparam int AW = $clog2(DEPTH);

    // One entry per position; default image returns on reset
    for (genvar g = 0; g < DEPTH; g++) begin : g_ent
        localparam logic [AW-1:0] IDX = AW'(g);
        localparam logic [7:0] HOST = 8'(g * `IPSL_HOST_STEP);
        localparam logic [WIDTH-1:0] DFLT =
            (g == 0) ? WIDTH'(`IPSL_RECOV_ADDR) :
            (g <= `IPSL_SEL_NET1_LAST) ? WIDTH'(`IPSL_NET1_BASE | {24'h000000, HOST}) :
            (g <= 14) ? WIDTH'(`IPSL_NET0_BASE | {24'h000000, HOST}) :
            {WIDTH{1'b0}};
        always_ff @(posedge i_mclk) begin
            if (!i_rst_n) begin
                mem_r[g] <= DFLT;
            end else if (i_we && i_waddr == IDX) begin
                mem_r[g] <= i_wdata;
            end
        end
    end

    // Read data from a register so the caller sees a clean value
    always_ff @(posedge i_mclk) begin
        rdata_r <= mem_r[i_raddr];
    end

    assign o_rdata = rdata_r;
endmodule // ipsl_addr_table
`default_nettype wire

// file: rtl/ipsl_session_lock.sv
// Network identity selection and command-session ownership.
// Assumes a stack in front that classifies each received segment
// into source endpoint, destination port and transport, same clock.
`timescale 1ns/1ps
`default_nettype none
`include "ipsl_consts.svh"
module ipsl_session_lock (
    // Clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    // Rotary selector pins, asynchronous
    input  wire logic [3:0]  i_sel_pin,
    // Table programming port
    input  wire logic        i_cfg_we,
    input  wire logic [3:0]  i_cfg_idx,
    input  wire logic [31:0] i_cfg_addr,
    // DHCP client result
    input  wire logic        i_dhcp_valid,
    input  wire logic [31:0] i_dhcp_ip,
    input  wire logic [31:0] i_dhcp_mask,
    // Received segment header
    input  wire logic        i_rx_valid,
    input  wire logic        i_rx_is_tcp,
    input  wire logic [31:0] i_rx_src_ip,
    input  wire logic [15:0] i_rx_src_port,
    input  wire logic [15:0] i_rx_dst_port,
    // Local identity
    output logic             o_cfg_ready,
    output logic             o_dhcp_req,
    output logic [31:0]      o_ip_addr,
    output logic [31:0]      o_ip_mask,
    // Receive verdict
    output logic             o_rx_accept,
    output logic             o_rx_refuse,
    // Response destination
    output logic             o_owned,
    output logic [31:0]      o_tx_dst_ip,
    output logic [15:0]      o_tx_dst_port,
    output logic             o_tx_is_tcp
);
    // Selector synchroniser stages
    logic [3:0]  sel_s1_r;
    logic [3:0]  sel_s2_r;
    // Sequencer state and its next value
    ipsl_pkg::ipsl_state_t state_r, state_nxt;
    logic [1:0]  settle_r, settle_nxt;
    logic [3:0]  sel_r, sel_nxt;
    logic [31:0] ip_r, ip_nxt;
    logic [31:0] mask_r, mask_nxt;
    // Table interface
    logic        tbl_we;
    logic [31:0] tbl_rdata;
    // Session lock state
    logic        owned_r, owned_nxt;
    logic [31:0] own_ip_r, own_ip_nxt;
    logic [15:0] own_port_r, own_port_nxt;
    logic        own_tcp_r, own_tcp_nxt;
    logic        acc_r, acc_nxt;
    logic        ref_r, ref_nxt;
    // Packet classification
    logic        cmd_port;
    logic        from_owner;
    // Helper for checks: table untouched since reset
    logic        touched_r;

    // Pins cross into the clock domain through two flops
    // No reset: the flops only carry the pin level, never decide on it
    always_ff @(posedge i_mclk) begin
        sel_s1_r <= i_sel_pin;
        sel_s2_r <= sel_s1_r;
    end

    assign tbl_we = i_cfg_we && (i_cfg_idx != `IPSL_SEL_RECOV);

    // Table of presets; read address follows the captured position
    ipsl_addr_table #(
        .DEPTH (16),
        .WIDTH (32)
    ) u_tbl (
        .i_mclk  (i_mclk),
        .i_rst_n (i_rst_n),
        .i_we    (tbl_we),
        .i_waddr (i_cfg_idx),
        .i_wdata (i_cfg_addr),
        .i_raddr (sel_r),
        .o_rdata (tbl_rdata)
    );

    // Sequencer next state
    always_comb begin
        state_nxt  = state_r;
        settle_nxt = settle_r;
        sel_nxt    = sel_r;
        ip_nxt     = ip_r;
        mask_nxt   = mask_r;
        case (state_r)
            // Let the synchroniser fill before trusting it
            ipsl_pkg::IPSL_ST_SETTLE: begin
                settle_nxt = 2'(settle_r + 2'h1);
                if (settle_r == `IPSL_SETTLE_CYC) begin
                    sel_nxt   = sel_s2_r;
                    state_nxt = ipsl_pkg::IPSL_ST_FETCH;
                end
            end
            // Table read is registered: one cycle of latency
            ipsl_pkg::IPSL_ST_FETCH: begin
                state_nxt = ipsl_pkg::IPSL_ST_LOAD;
            end
            ipsl_pkg::IPSL_ST_LOAD: begin
                if (sel_r == `IPSL_SEL_DHCP) begin
                    state_nxt = ipsl_pkg::IPSL_ST_DHCP;
                end else if (sel_r == `IPSL_SEL_RECOV) begin
                    // recovery address, class A
                    // Bypasses the table so a bad image cannot hide the unit
                    ip_nxt    = `IPSL_RECOV_ADDR;
                    mask_nxt  = `IPSL_MASK_A;
                    state_nxt = ipsl_pkg::IPSL_ST_READY;
                end else begin
                    ip_nxt    = tbl_rdata;
                    mask_nxt  = `IPSL_MASK_B;
                    state_nxt = ipsl_pkg::IPSL_ST_READY;
                end
            end
            ipsl_pkg::IPSL_ST_DHCP: begin
                // No time limit here; the lease client owns its retries
                // lease gives address and mask
                if (i_dhcp_valid) begin
                    ip_nxt    = i_dhcp_ip;
                    mask_nxt  = i_dhcp_mask;
                    state_nxt = ipsl_pkg::IPSL_ST_READY;
                end
            end
            // Identity is frozen; later leases are ignored
            ipsl_pkg::IPSL_ST_READY: begin
                state_nxt = ipsl_pkg::IPSL_ST_READY;
            end
            default: begin
                state_nxt = ipsl_pkg::IPSL_ST_SETTLE;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            state_r  <= ipsl_pkg::IPSL_ST_SETTLE;
            settle_r <= 2'h0;
            sel_r    <= 4'h0;
            ip_r     <= 32'h00000000;
            mask_r   <= 32'h00000000;
        end else begin
            state_r  <= state_nxt;
            settle_r <= settle_nxt;
            sel_r    <= sel_nxt;
            ip_r     <= ip_nxt;
            mask_r   <= mask_nxt;
        end
    end

    // A port reached over the wrong transport is not a command: no verdict
    // either transport on its own port
    assign cmd_port = i_rx_valid &&
        ((!i_rx_is_tcp && i_rx_dst_port == `IPSL_UDP_PORT) ||
         (i_rx_is_tcp && i_rx_dst_port == `IPSL_TCP_PORT));
    // A host that reopens its socket on a new port keeps its ownership
    // owner match on address only; source port is free
    assign from_owner = (i_rx_src_ip == own_ip_r);

    // Lock next state; nothing but reset at power-up ever clears it
    // lock held until power-down
    always_comb begin
        owned_nxt    = owned_r;
        own_ip_nxt   = own_ip_r;
        own_port_nxt = own_port_r;
        own_tcp_nxt  = own_tcp_r;
        acc_nxt      = 1'b0;
        ref_nxt      = 1'b0;
        if (cmd_port) begin
            // Traffic before the identity settles is refused
            if (state_r != ipsl_pkg::IPSL_ST_READY) begin
                ref_nxt = 1'b1;
            end else if (!owned_r) begin
                acc_nxt      = 1'b1;
                owned_nxt    = 1'b1;
                own_ip_nxt   = i_rx_src_ip;
                own_port_nxt = i_rx_src_port;
                own_tcp_nxt  = i_rx_is_tcp;
            end else if (from_owner) begin
                acc_nxt = 1'b1;
            end else begin
                ref_nxt = 1'b1;
            end
        end
    end

    // Lock registers
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            owned_r    <= 1'b0;
            own_ip_r   <= 32'h00000000;
            own_port_r <= 16'h0000;
            own_tcp_r  <= 1'b0;
            acc_r      <= 1'b0;
            ref_r      <= 1'b0;
        end else begin
            owned_r    <= owned_nxt;
            own_ip_r   <= own_ip_nxt;
            own_port_r <= own_port_nxt;
            own_tcp_r  <= own_tcp_nxt;
            acc_r      <= acc_nxt;
            ref_r      <= ref_nxt;
        end
    end

    // Check helper: any table write since reset
    // Lets the default-address check skip boots that rewrite the table
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            touched_r <= 1'b0;
        end else begin
            touched_r <= touched_r | tbl_we;
        end
    end

    // Outputs
    assign o_cfg_ready   = (state_r == ipsl_pkg::IPSL_ST_READY);
    assign o_dhcp_req    = (state_r == ipsl_pkg::IPSL_ST_DHCP);
    assign o_ip_addr     = ip_r;
    assign o_ip_mask     = mask_r;
    assign o_rx_accept   = acc_r;
    assign o_rx_refuse   = ref_r;
    // responses go to the latched endpoint
    assign o_owned       = owned_r;
    assign o_tx_dst_ip   = own_ip_r;
    assign o_tx_dst_port = own_port_r;
    assign o_tx_is_tcp   = own_tcp_r;

    // Checks
    // Reset is synchronous, so every check sleeps while it is held
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    sequence s_load(logic [3:0] p);
        state_r == ipsl_pkg::IPSL_ST_LOAD && sel_r == p;
    endsequence
    sequence s_ready_cmd;
        cmd_port && state_r == ipsl_pkg::IPSL_ST_READY;
    endsequence
    sequence s_lease;
        state_r == ipsl_pkg::IPSL_ST_DHCP && i_dhcp_valid;
    endsequence

    AST_RECOV_ADDR: assert property (s_load(4'h0) |=>
        o_ip_addr == 32'h0a0a0a0a && o_cfg_ready)
        else $error("Position 0 did not give the recovery address");
    AST_NET0_DFLT: assert property (
        s_load(4'h9) ##0 !touched_r |=> o_ip_addr == 32'hc0a8005a)
        else $error("Position 9 default address wrong");
    AST_DHCP_REQ: assert property (s_load(4'hf) |=>
        o_dhcp_req && !o_cfg_ready)
        else $error("Position F did not request a lease");
    AST_DHCP_SEQ: assert property (s_lease |=>
        o_cfg_ready && o_ip_addr == $past(i_dhcp_ip) && o_ip_mask == $past(i_dhcp_mask))
        else $error("DHCP lease not adopted");
    AST_EARLY_REFUSE: assert property (cmd_port && !o_cfg_ready |=>
        o_rx_refuse && !o_rx_accept && !o_owned)
        else $error("Command before identity settled was not refused");
    AST_MASK_B: assert property (o_cfg_ready && sel_r != 4'h0
        && sel_r != 4'hf |-> o_ip_mask == 32'hffff0000)
        else $error("Preset position lacks class B mask");
    AST_MASK_A: assert property (
        o_cfg_ready && sel_r == 4'h0 |-> o_ip_mask == 32'hff000000)
        else $error("Recovery address lacks class A mask");
    AST_UDP_OWNER: assert property (s_ready_cmd ##0 !i_rx_is_tcp
        ##0 (from_owner || !owned_r) |=> o_rx_accept && !o_rx_refuse)
        else $error("UDP command from owner not accepted");
    AST_TCP_OWNER: assert property (s_ready_cmd ##0 i_rx_is_tcp
        ##0 (from_owner || !owned_r) |=> o_rx_accept)
        else $error("TCP command from owner not accepted");
    AST_FIRST_LATCH: assert property (s_ready_cmd ##0 !owned_r |=>
        o_owned && o_tx_dst_ip == $past(i_rx_src_ip)
        && o_tx_dst_port == $past(i_rx_src_port) && o_tx_is_tcp == $past(i_rx_is_tcp))
        else $error("First sender not latched as owner");
    AST_STRANGER: assert property (s_ready_cmd ##0 owned_r
        ##0 !from_owner |=> o_rx_refuse && !o_rx_accept)
        else $error("Foreign source not refused");
    AST_LOCK_HOLD: assert property (o_owned |=> o_owned
        && $stable(o_tx_dst_ip) && $stable(o_tx_dst_port))
        else $error("Ownership changed while powered");
    AST_FIXED_ZERO: assert property (
        i_cfg_we && i_cfg_idx == 4'h0 |=> $stable(u_tbl.mem_r[0]))
        else $error("Position 0 entry was written");
    AST_FROZEN: assert property (o_cfg_ready |=>
        o_cfg_ready && $stable(o_ip_addr) && $stable(o_ip_mask))
        else $error("Identity changed after power-up");
endmodule // ipsl_session_lock
`default_nettype wire

// file: tb/ipsl_host_model.sv
// Host model: presents received segment headers to the session lock.
// Assumes one clock shared with the block; released fields scramble.
`timescale 1ns/1ps
`default_nettype none
module ipsl_host_model (
    // Clock
    input  wire logic   i_mclk,
    // Segment header toward the block
    output logic        o_rx_valid,
    output logic        o_rx_is_tcp,
    output logic [31:0] o_rx_src_ip,
    output logic [15:0] o_rx_src_port,
    output logic [15:0] o_rx_dst_port
);
    // Idle header at time zero
    initial begin
        o_rx_valid    = 1'b0;
        o_rx_is_tcp   = 1'b0;
        o_rx_src_ip   = 32'h0;
        o_rx_src_port = 16'h0;
        o_rx_dst_port = 16'h0;
    end
    // One segment per edge; calls may follow back to back
    task automatic send(input logic tcp, input logic [31:0] ip,
                        input logic [15:0] sp, input logic [15:0] dp);
        @(posedge i_mclk);
        #1;
        o_rx_valid    = 1'b1;
        o_rx_is_tcp   = tcp;
        o_rx_src_ip   = ip;
        o_rx_src_port = sp;
        o_rx_dst_port = dp;
    endtask
    // Release: inverse values so stale fields never match by luck
    task automatic idle();
        @(posedge i_mclk);
        #1;
        o_rx_valid    = 1'b0;
        o_rx_is_tcp   = ~o_rx_is_tcp;
        o_rx_src_ip   = ~o_rx_src_ip;
        o_rx_src_port = ~o_rx_src_port;
        o_rx_dst_port = ~o_rx_dst_port;
    endtask
endmodule // ipsl_host_model
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the IP selection and session lock block.
// Assumes a 10 MHz clock; each boot stands for one power cycle.
`timescale 1ns/1ps
`default_nettype none
`include "ipsl_consts.svh"
module testbench;
    // Clock, reset and block inputs
    logic        i_mclk, i_rst_n, i_cfg_we, i_dhcp_valid;
    logic [3:0]  i_sel_pin, i_cfg_idx;
    logic [31:0] i_cfg_addr, i_dhcp_ip, i_dhcp_mask;
    // Host lines and block outputs
    logic        rx_valid, rx_tcp, o_cfg_ready, o_dhcp_req;
    logic [31:0] rx_ip, o_ip_addr, o_ip_mask, o_tx_dst_ip;
    logic [15:0] rx_sp, rx_dp, o_tx_dst_port;
    logic        o_rx_accept, o_rx_refuse, o_owned, o_tx_is_tcp;
    // Bookkeeping
    int          fails, checked, cycles, seed, p;
    logic [31:0] ip_a, ip_b, lease;
    logic [15:0] pa, pb;
    logic [51:0] notes[$];
    logic [51:0] note, seen_v;
    logic [63:0] ident;
    ipsl_session_lock u_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_sel_pin(i_sel_pin),
        .i_cfg_we(i_cfg_we), .i_cfg_idx(i_cfg_idx), .i_cfg_addr(i_cfg_addr),
        .i_dhcp_valid(i_dhcp_valid), .i_dhcp_ip(i_dhcp_ip), .i_dhcp_mask(i_dhcp_mask),
        .i_rx_valid(rx_valid), .i_rx_is_tcp(rx_tcp), .i_rx_src_ip(rx_ip),
        .i_rx_src_port(rx_sp), .i_rx_dst_port(rx_dp), .o_cfg_ready(o_cfg_ready),
        .o_dhcp_req(o_dhcp_req), .o_ip_addr(o_ip_addr), .o_ip_mask(o_ip_mask),
        .o_rx_accept(o_rx_accept), .o_rx_refuse(o_rx_refuse), .o_owned(o_owned),
        .o_tx_dst_ip(o_tx_dst_ip), .o_tx_dst_port(o_tx_dst_port), .o_tx_is_tcp(o_tx_is_tcp));
    ipsl_host_model u_host (.i_mclk(i_mclk), .o_rx_valid(rx_valid), .o_rx_is_tcp(rx_tcp),
        .o_rx_src_ip(rx_ip), .o_rx_src_port(rx_sp), .o_rx_dst_port(rx_dp));
    // 100 ns clock
    initial begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end
    // Compare one value, count it, report a miss
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Factory identity of a preset position
    function automatic logic [63:0] preset(input logic [3:0] s);
        if (s == 4'h0) return {`IPSL_RECOV_ADDR, `IPSL_MASK_A};
        if (s <= 4'h3) return {`IPSL_NET1_BASE + 32'(s) * 32'h0a, `IPSL_MASK_B};
        return {`IPSL_NET0_BASE + 32'(s) * 32'h0a, `IPSL_MASK_B};
    endfunction
    // Power cycle with the selector set, one table write in the settle window
    task automatic boot(input logic [3:0] s, input logic [3:0] idx, input logic [31:0] v);
        @(posedge i_mclk);
        #1;
        i_rst_n   = 1'b0;
        i_sel_pin = s;
        repeat (12) @(posedge i_mclk);
        #1;
        i_rst_n = 1'b1;
        @(posedge i_mclk);
        #1;
        {i_cfg_we, i_cfg_idx, i_cfg_addr} = {1'b1, idx, v};
        @(posedge i_mclk);
        #1;
        i_cfg_we = 1'b0;
    endtask
    // Bounded wait for a settled identity
    task automatic wait_ready();
        for (int n = 0; n < 20 && o_cfg_ready !== 1'b1; n++) begin
            @(posedge i_mclk);
            #1;
        end
        ident = {o_ip_addr, o_ip_mask};
    endtask
    // Note the verdict, then hand the segment to the host
    task automatic seg(input logic t, input logic [31:0] ip, input logic [15:0] sp,
                       input logic [15:0] dp, input logic [1:0] v, input logic [51:0] own);
        if (v != 2'b00) notes.push_back({v, own[49:0]});
        u_host.send(t, ip, sp, dp);
    endtask
    // Verdict monitor: oldest note against each pulse
    always @(posedge i_mclk) begin
        #2;
        if (o_rx_accept === 1'b1 || o_rx_refuse === 1'b1) begin
            note = (notes.size() > 0) ? notes.pop_front() : 'x;
            seen_v = {o_rx_accept, o_rx_refuse, o_owned, o_tx_dst_ip, o_tx_dst_port, o_tx_is_tcp};
            check("verdict", seen_v, note);
        end
    end
    // Hang guard
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            tally_and_finish();
        end
    end
    initial begin
        {fails, checked, cycles, seed} = {32'd0, 32'd0, 32'd0, 32'd93223};
        {i_rst_n, i_cfg_we, i_dhcp_valid, i_sel_pin, i_cfg_idx} = 11'h0;
        {i_cfg_addr, i_dhcp_ip, i_dhcp_mask} = 96'h0;
        // Every preset position after its own power cycle
        for (p = 0; p < 15; p++) begin
            boot(4'(p), 4'h0, 32'h0);
            wait_ready();
            check("identity", ident, preset(4'(p)));
        end
        // Rewritten entry is used at the next capture
        lease = $random(seed);
        boot(4'h5, 4'h5, lease);
        wait_ready();
        check("table entry", ident, {lease, `IPSL_MASK_B});
        // Position 0 entry stays fixed; later selector and leases are ignored
        boot(4'h0, 4'h0, lease);
        wait_ready();
        {i_sel_pin, i_dhcp_valid, i_dhcp_ip} = {4'h7, 1'b1, lease};
        repeat (6) @(posedge i_mclk);
        #1;
        check("fixed recovery", {o_ip_addr, o_ip_mask}, preset(4'h0));
        i_dhcp_valid = 1'b0;
        // Lease acquisition; command before ready is refused
        boot(4'hf, 4'h0, 32'h0);
        ip_a = $random(seed);
        ip_b = ip_a ^ 32'h1;
        pa   = $random(seed);
        pb   = $random(seed);
        seg(1'b0, ip_a, pa, `IPSL_UDP_PORT, 2'b01, 52'h0);
        u_host.idle();
        repeat (4) @(posedge i_mclk);
        #1;
        check("lease request", {o_dhcp_req, o_cfg_ready}, 64'h2);
        lease = $random(seed);
        {i_dhcp_valid, i_dhcp_ip, i_dhcp_mask} = {1'b1, lease, 32'hfffffc00};
        @(posedge i_mclk);
        #1;
        // A second lease after the first must be ignored
        {i_dhcp_valid, i_dhcp_ip} = {1'b1, ~lease};
        @(posedge i_mclk);
        #1;
        i_dhcp_valid = 1'b0;
        check("lease ready", {o_dhcp_req, o_cfg_ready}, 64'h1);
        check("lease identity", {o_ip_addr, o_ip_mask}, {lease, 32'hfffffc00});
        // First sender owns; others refused; wrong port or transport ignored
        seg(1'b0, ip_a, pa, `IPSL_UDP_PORT, 2'b10, {1'b1, ip_a, pa, 1'b0});
        seg(1'b0, ip_b, pb, `IPSL_UDP_PORT, 2'b01, {1'b1, ip_a, pa, 1'b0});
        seg(1'b1, ip_a, pb, `IPSL_TCP_PORT, 2'b10, {1'b1, ip_a, pa, 1'b0});
        seg(1'b1, ip_b, pb, `IPSL_UDP_PORT, 2'b00, 52'h0);
        seg(1'b0, ip_b, pb, 16'h0050, 2'b00, 52'h0);
        u_host.idle();
        repeat (20) @(posedge i_mclk);
        seg(1'b1, ip_b, pb, `IPSL_TCP_PORT, 2'b01, {1'b1, ip_a, pa, 1'b0});
        u_host.idle();
        // Only a power cycle frees the lock
        boot(4'h1, 4'h0, 32'h0);
        wait_ready();
        seg(1'b1, ip_b, pb, `IPSL_TCP_PORT, 2'b10, {1'b1, ip_b, pb, 1'b1});
        u_host.idle();
        repeat (3) @(posedge i_mclk);
        check("notes left", 64'(notes.size()), 64'h0);
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
